// ==== hw/btu_branch_target.sv ====
// Branch target unit: target forming, conditions, call and return frames
`timescale 1ns/1ns
module btu_branch_target
(
    input  wire logic          REF_CLK_IN,
    input  wire logic          RST_IN,
    input  wire logic          CLK_EN_IN,
    input  wire logic [7:0]    REG_ADDR_IN,
    input  wire logic [31:0]   REG_WDATA_IN,
    input  wire logic          REG_WR_IN,
    input  wire logic          REG_RD_IN,
    output logic [31:0]        REG_RDATA_OUT,
    input  wire logic          OP_VALID_IN,
    input  btu_pkg::btu_op_e   OP_CODE_IN,
    input  btu_pkg::btu_cond_e COND_IN,
    input  wire logic [23:0]   NEXT_PC_IN,
    input  wire logic [7:0]    REL_IN,
    input  wire logic [23:0]   TARGET_IN,
    input  wire logic [15:0]   WORD_REG_IN,
    input  wire logic [7:0]    ACC_IN,
    input  wire logic [15:0]   DATA_POINTER_REG_IN,
    input  wire logic [7:0]    FLAGS_IN,
    input  wire logic [7:0]    EXTRA_FLAGS_IN,
    input  wire logic          BIT_IN,
    output logic               OP_READY_OUT,
    output logic               PC_LOAD_OUT,
    output logic [23:0]        PC_OUT,
    output logic               TAKEN_OUT,
    output logic               BIT_CLEAR_OUT,
    output logic               STK_WR_OUT,
    output logic [7:0]         STK_WDATA_OUT,
    output logic               STK_RD_OUT,
    input  wire logic [7:0]    STK_RDATA_IN,
    output logic               IRQ_RELEASE_OUT,
    output logic               EXTRA_FLAGS_LOAD_OUT,
    output logic [7:0]         EXTRA_FLAGS_OUT
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_POP,
        ST_CAP,
        ST_DONE
    } btu_state_e;

    function automatic logic [23:0] splice(input logic [23:0] base,
                                           input logic [23:0] val,
                                           input logic [23:0] mask);
        splice = (base & ~mask) | (val & mask);
    endfunction

    function automatic logic [23:0] sext8(input logic [7:0] v);
        sext8 = {{16{v[7]}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    btu_state_e  state_q;
    logic        cfg_long_q;
    logic        frame_q;
    logic [23:0] pc_q;
    logic        pc_load_q;
    logic        taken_q;
    logic        bit_clr_q;
    logic        irq_rel_q;
    logic        xfl_ld_q;
    logic [7:0]  xfl_q;
    logic [23:0] tgt_q;
    logic [7:0]  hi_q;
    logic [7:0]  push_q [0:3];
    logic [7:0]  pop_q [0:3];
    logic [1:0]  idx_q;
    logic [2:0]  len_q;
    logic        is_pop_q;
    btu_pkg::btu_op_e op_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Target forming

    wire         idle = (state_q == ST_IDLE);
    wire         accept = OP_VALID_IN && idle && CLK_EN_IN;
    wire [7:0]   pc_lo = NEXT_PC_IN[7:0];
    wire [7:0]   pc_mi = NEXT_PC_IN[15:8];
    wire [7:0]   pc_hi = NEXT_PC_IN[23:16];
    wire [23:0]  rel_ext = sext8(REL_IN);
    wire [23:0]  rel_tgt = NEXT_PC_IN + rel_ext;
    // Conditional offset wraps in the current 256-byte block
    wire [7:0]   cond_lo = pc_lo + REL_IN;
    wire [23:0]  cond_tgt = {NEXT_PC_IN[23:8], cond_lo};
    wire [23:0]  blk_tgt = splice(NEXT_PC_IN, TARGET_IN,
                                  btu_pkg::MASK_11);
    wire [23:0]  rgn_tgt = splice(NEXT_PC_IN, TARGET_IN,
                                  btu_pkg::MASK_16);
    wire [23:0]  word_tgt = splice(NEXT_PC_IN, {8'h00, WORD_REG_IN},
                                   btu_pkg::MASK_16);
    wire [15:0]  ad_sum = DATA_POINTER_REG_IN + {8'h00, ACC_IN};
    wire [23:0]  ad_tgt = {btu_pkg::CODE_REGION, ad_sum};
    wire         cond_ok;
    wire         cy = FLAGS_IN[btu_pkg::FLAG_CY_BIT];

    btu_cond_eval u_cond
    (
        .op_in          (OP_CODE_IN),
        .cond_in        (COND_IN),
        .flags_in       (FLAGS_IN),
        .extra_flags_in (EXTRA_FLAGS_IN),
        .bit_in         (BIT_IN),
        .taken_out      (cond_ok)
    );

    logic [23:0] tgt_d;
    logic [2:0]  push_n;
    logic [2:0]  pop_n;
    logic [7:0]  pb [0:3];

    always_comb
    begin
        tgt_d = NEXT_PC_IN;
        push_n = btu_pkg::FRAME_NONE;
        pop_n = btu_pkg::FRAME_NONE;
        pb[0] = pc_lo;
        pb[1] = pc_mi;
        pb[2] = 8'h00;
        pb[3] = 8'h00;
        case (OP_CODE_IN)
            btu_pkg::OP_SHORT_JUMP:        tgt_d = rel_tgt;
            btu_pkg::OP_CMP_BRANCH,
            btu_pkg::OP_BRANCH_ON_SET_BIT,
            btu_pkg::OP_BRANCH_ON_CLEAR_BIT,
            btu_pkg::OP_BRANCH_AND_CLEAR_BIT:
                tgt_d = cond_ok ? cond_tgt : NEXT_PC_IN;
            btu_pkg::OP_BLOCK_LOCAL_JUMP:  tgt_d = blk_tgt;
            btu_pkg::OP_REGION_LOCAL_JUMP: tgt_d = rgn_tgt;
            btu_pkg::OP_EXTENDED_JUMP:     tgt_d = TARGET_IN;
            btu_pkg::OP_WORD_REG_JUMP:     tgt_d = word_tgt;
            btu_pkg::OP_ACC_DATA_POINTER_REG_JUMP:     tgt_d = ad_tgt;
            btu_pkg::OP_BLOCK_LOCAL_CALL:
            begin
                tgt_d = blk_tgt;
                push_n = btu_pkg::FRAME_SHORT;
            end
            btu_pkg::OP_REGION_LOCAL_CALL:
            begin
                tgt_d = rgn_tgt;
                push_n = btu_pkg::FRAME_SHORT;
            end
            btu_pkg::OP_WORD_REG_CALL:
            begin
                tgt_d = word_tgt;
                push_n = btu_pkg::FRAME_SHORT;
            end
            btu_pkg::OP_EXTENDED_CALL:
            begin
                tgt_d = TARGET_IN;
                push_n = btu_pkg::FRAME_EXT;
                pb[0] = pc_hi;
                pb[1] = pc_lo;
                pb[2] = pc_mi;
            end
            btu_pkg::OP_IRQ_ENTRY:
            begin
                tgt_d = TARGET_IN;
                push_n = btu_pkg::FRAME_SHORT;
                if (cfg_long_q)
                begin
                    push_n = btu_pkg::FRAME_LONG_IRQ;
                    pb[0] = EXTRA_FLAGS_IN;
                    pb[1] = pc_hi;
                    pb[2] = pc_lo;
                    pb[3] = pc_mi;
                end
            end
            btu_pkg::OP_NEAR_GO_BACK:    pop_n = btu_pkg::FRAME_SHORT;
            btu_pkg::OP_EXTENDED_GO_BACK: pop_n = btu_pkg::FRAME_EXT;
            btu_pkg::OP_INTERRUPT_EXIT:
                pop_n = cfg_long_q ? btu_pkg::FRAME_LONG_IRQ
                                   : btu_pkg::FRAME_SHORT;
            default:                     tgt_d = NEXT_PC_IN;
        endcase
    end

    // Popped bytes come back middle first, then low, then top, then flags
    logic [23:0] ret_tgt;

    always_comb
    begin
        case (op_q)
            btu_pkg::OP_NEAR_GO_BACK:
                ret_tgt = {hi_q, pop_q[0], pop_q[1]};
            btu_pkg::OP_EXTENDED_GO_BACK:
                ret_tgt = {pop_q[2], pop_q[0], pop_q[1]};
            btu_pkg::OP_INTERRUPT_EXIT:
                ret_tgt = frame_q ? {pop_q[2], pop_q[0], pop_q[1]}
                                  : {btu_pkg::CODE_REGION,
                                     pop_q[0], pop_q[1]};
            default:
                ret_tgt = {hi_q, pop_q[0], pop_q[1]};
        endcase
    end

    wire last = ({1'b0, idx_q} == (len_q - 3'h1));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge REF_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state_q <= ST_IDLE;
            pc_q <= btu_pkg::PC_RST;
            pc_load_q <= 1'b0;
            taken_q <= 1'b0;
            bit_clr_q <= 1'b0;
            irq_rel_q <= 1'b0;
            xfl_ld_q <= 1'b0;
            xfl_q <= 8'h00;
            tgt_q <= btu_pkg::PC_RST;
            hi_q <= 8'h00;
            idx_q <= 2'h0;
            len_q <= btu_pkg::FRAME_NONE;
            is_pop_q <= 1'b0;
            op_q <= btu_pkg::OP_NOP;
            frame_q <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            pc_load_q <= 1'b0;
            bit_clr_q <= 1'b0;
            irq_rel_q <= 1'b0;
            xfl_ld_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (OP_VALID_IN)
                    begin
                        op_q <= OP_CODE_IN;
                        tgt_q <= tgt_d;
                        hi_q <= pc_hi;
                        idx_q <= 2'h0;
                        frame_q <= cfg_long_q;
                        len_q <= push_n | pop_n;
                        is_pop_q <= (pop_n != btu_pkg::FRAME_NONE);
                        if (push_n != btu_pkg::FRAME_NONE)
                            state_q <= ST_PUSH;
                        else if (pop_n != btu_pkg::FRAME_NONE)
                            state_q <= ST_POP;
                        else
                        begin
                            pc_q <= tgt_d;
                            pc_load_q <= 1'b1;
                            taken_q <= cond_ok;
                            bit_clr_q <= cond_ok && (OP_CODE_IN ==
                                btu_pkg::OP_BRANCH_AND_CLEAR_BIT);
                        end
                    end
                ST_PUSH:
                begin
                    idx_q <= idx_q + 2'h1;
                    if (last)
                    begin
                        // Counter moves only after the whole frame is out
                        pc_q <= tgt_q;
                        pc_load_q <= 1'b1;
                        taken_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_POP:
                    state_q <= ST_CAP;
                ST_CAP:
                begin
                    idx_q <= idx_q + 2'h1;
                    state_q <= last ? ST_DONE : ST_POP;
                end
                ST_DONE:
                begin
                    pc_q <= ret_tgt;
                    pc_load_q <= 1'b1;
                    taken_q <= 1'b1;
                    irq_rel_q <= (op_q == btu_pkg::OP_INTERRUPT_EXIT);
                    xfl_ld_q <= (op_q == btu_pkg::OP_INTERRUPT_EXIT)
                                && frame_q;
                    xfl_q <= pop_q[3];
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Frame storage, indexed by the byte counter
    always_ff @(posedge REF_CLK_IN)
    begin
        if (CLK_EN_IN && accept)
            push_q <= pb;
        if (CLK_EN_IN && state_q == ST_CAP)
            pop_q[idx_q] <= STK_RDATA_IN;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    wire sel_cfg = (REG_ADDR_IN == btu_pkg::REG_CONFIG);
    wire sel_sts = (REG_ADDR_IN == btu_pkg::REG_STATUS);
    wire sel_tgt = (REG_ADDR_IN == btu_pkg::REG_TARGET);
    wire [31:0] rd_mux = sel_cfg ? {31'h0, cfg_long_q}
                       : sel_sts ? {30'h0, taken_q, !idle}
                       : sel_tgt ? {8'h00, pc_q}
                       : 32'h0000_0000;

    always_ff @(posedge REF_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            cfg_long_q <= btu_pkg::CFG_LONG_FRAME_RST;
            rdata_q <= 32'h0000_0000;
        end
        else if (CLK_EN_IN)
        begin
            if (REG_WR_IN && sel_cfg)
                cfg_long_q <= REG_WDATA_IN[btu_pkg::CFG_LONG_FRAME_BIT];
            rdata_q <= REG_RD_IN ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Strobes gated by the enable so a frozen cycle makes no extra access
    assign STK_WR_OUT = (state_q == ST_PUSH) && CLK_EN_IN;
    assign STK_WDATA_OUT = push_q[idx_q];
    assign STK_RD_OUT = (state_q == ST_POP) && CLK_EN_IN;
    assign OP_READY_OUT = idle;
    assign PC_OUT = pc_q;
    assign PC_LOAD_OUT = pc_load_q;
    assign TAKEN_OUT = taken_q;
    assign BIT_CLEAR_OUT = bit_clr_q;
    assign IRQ_RELEASE_OUT = irq_rel_q;
    assign EXTRA_FLAGS_LOAD_OUT = xfl_ld_q;
    assign EXTRA_FLAGS_OUT = xfl_q;
    assign REG_RDATA_OUT = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    wire op_sj = accept && OP_CODE_IN == btu_pkg::OP_SHORT_JUMP;
    wire op_cnd = accept && OP_CODE_IN == btu_pkg::OP_CMP_BRANCH;

    rel_jump_a: assert property (op_sj |=> PC_LOAD_OUT &&
        (PC_OUT - $past(NEXT_PC_IN)) == $past(rel_ext))
        else $error("short jump target wrong");
    block_jump_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_BLOCK_LOCAL_JUMP |=>
        (PC_OUT & ~btu_pkg::MASK_11) ==
        ($past(NEXT_PC_IN) & ~btu_pkg::MASK_11) &&
        (PC_OUT & btu_pkg::MASK_11) == ($past(TARGET_IN) & btu_pkg::MASK_11))
        else $error("block jump left its block");
    region_jump_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_REGION_LOCAL_JUMP |=>
        (PC_OUT >> 16) == ($past(NEXT_PC_IN) >> 16) &&
        (PC_OUT & btu_pkg::MASK_16) == ($past(TARGET_IN) & btu_pkg::MASK_16))
        else $error("region jump left its region");
    ext_jump_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_EXTENDED_JUMP |=>
        PC_LOAD_OUT && PC_OUT == $past(TARGET_IN))
        else $error("extended jump target wrong");
    word_jump_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_WORD_REG_JUMP |=>
        (PC_OUT >> 16) == ($past(NEXT_PC_IN) >> 16) &&
        PC_OUT[15:0] == $past(WORD_REG_IN))
        else $error("word register jump wrong");
    acc_data_pointer_reg_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_ACC_DATA_POINTER_REG_JUMP |=>
        PC_OUT[23:16] == 8'hFF &&
        PC_OUT[15:0] == $past(DATA_POINTER_REG_IN) + {8'h00, $past(ACC_IN)})
        else $error("indexed jump wrong");
    cond_block_a: assert property (op_cnd |=>
        (PC_OUT >> 8) == ($past(NEXT_PC_IN) >> 8))
        else $error("conditional branch left its block");
    bit_clear_a: assert property (BIT_CLEAR_OUT |->
        TAKEN_OUT && op_q == btu_pkg::OP_BRANCH_AND_CLEAR_BIT)
        else $error("bit cleared without taken branch");
    ucmp_a: assert property (
        op_cnd && COND_IN == btu_pkg::COND_ULT |=> TAKEN_OUT == $past(cy))
        else $error("unsigned less test wrong");
    nop_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_NOP |=>
        PC_LOAD_OUT && TAKEN_OUT && PC_OUT == $past(NEXT_PC_IN))
        else $error("no-operation target wrong");
    call_push_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_REGION_LOCAL_CALL ##1 CLK_EN_IN
        |-> STK_WR_OUT && !PC_LOAD_OUT &&
        {16'h0000, STK_WDATA_OUT} == ($past(NEXT_PC_IN) & 24'h0000FF))
        else $error("call did not push low byte first");
    ext_call_a: assert property (
        accept && OP_CODE_IN == btu_pkg::OP_EXTENDED_CALL
        ##1 CLK_EN_IN [*3] |=> PC_LOAD_OUT && !STK_WR_OUT &&
        PC_OUT == $past(TARGET_IN, 4))
        else $error("extended call frame length wrong");
    irq_exit_a: assert property (
        IRQ_RELEASE_OUT && !frame_q |-> PC_LOAD_OUT &&
        PC_OUT[23:16] == btu_pkg::CODE_REGION && !EXTRA_FLAGS_LOAD_OUT)
        else $error("short frame exit outside region FF");
    long_frame_a: assert property (
        EXTRA_FLAGS_LOAD_OUT |-> IRQ_RELEASE_OUT && frame_q &&
        EXTRA_FLAGS_OUT == pop_q[3])
        else $error("long frame flags restore wrong");

    ext_call_c: cover property (
        accept && OP_CODE_IN == btu_pkg::OP_EXTENDED_CALL);
    long_exit_c: cover property (EXTRA_FLAGS_LOAD_OUT);
    bit_clear_c: cover property (BIT_CLEAR_OUT);
    not_taken_c: cover property (PC_LOAD_OUT && !TAKEN_OUT);

endmodule

// ==== hw/btu_cond_eval.sv ====
// Branch condition evaluator for bit and compare branches
`timescale 1ns/1ns
module btu_cond_eval
(
    input  btu_pkg::btu_op_e   op_in,
    input  btu_pkg::btu_cond_e cond_in,
    input  wire logic [7:0]    flags_in,
    input  wire logic [7:0]    extra_flags_in,
    input  wire logic          bit_in,
    output logic               taken_out
);

    wire cy = flags_in[btu_pkg::FLAG_CY_BIT];
    wire ov = flags_in[btu_pkg::FLAG_OV_BIT];
    wire n  = extra_flags_in[btu_pkg::XFLAG_N_BIT];
    wire z  = extra_flags_in[btu_pkg::XFLAG_Z_BIT];
    // Signed less: sign differs from overflow after the compare
    wire slt = n ^ ov;

    logic cmp_true;

    // Flags are taken as a compare left them, whatever set them
    always_comb
    begin
        case (cond_in)
            btu_pkg::COND_EQ:  cmp_true = z;
            btu_pkg::COND_NE:  cmp_true = !z;
            btu_pkg::COND_UGT: cmp_true = !cy && !z;
            btu_pkg::COND_ULT: cmp_true = cy;
            btu_pkg::COND_UGE: cmp_true = !cy;
            btu_pkg::COND_ULE: cmp_true = cy || z;
            btu_pkg::COND_SGT: cmp_true = !z && !slt;
            btu_pkg::COND_SLT: cmp_true = slt;
            btu_pkg::COND_SGE: cmp_true = !slt;
            btu_pkg::COND_SLE: cmp_true = z || slt;
            default:           cmp_true = 1'b0;
        endcase
    end

    always_comb
    begin
        case (op_in)
            btu_pkg::OP_CMP_BRANCH:           taken_out = cmp_true;
            btu_pkg::OP_BRANCH_ON_SET_BIT:    taken_out = bit_in;
            btu_pkg::OP_BRANCH_ON_CLEAR_BIT:  taken_out = !bit_in;
            btu_pkg::OP_BRANCH_AND_CLEAR_BIT: taken_out = bit_in;
            default:                          taken_out = 1'b1;
        endcase
    end

endmodule

// ==== hw/btu_pkg.sv ====
// Constants, field layouts and enumerations of the branch target unit
package btu_pkg;

    localparam int PC_W = 24;

    // Register map, byte addresses
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TARGET = 8'h08;

    localparam int CFG_LONG_FRAME_BIT = 0;
    localparam logic CFG_LONG_FRAME_RST = 1'b0;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_TAKEN_BIT = 1;

    // Flag positions in flags_word and extra_flags_word
    localparam int FLAG_CY_BIT = 7;
    localparam int FLAG_OV_BIT = 2;
    localparam int XFLAG_N_BIT = 5;
    localparam int XFLAG_Z_BIT = 1;

    localparam logic [7:0] CODE_REGION = 8'hFF;
    localparam logic [23:0] MASK_11 = 24'h0007FF;
    localparam logic [23:0] MASK_16 = 24'h00FFFF;
    localparam logic [23:0] PC_RST = 24'h000000;

    // Stack frame lengths in bytes
    localparam logic [2:0] FRAME_SHORT = 3'h2;
    localparam logic [2:0] FRAME_EXT = 3'h3;
    localparam logic [2:0] FRAME_LONG_IRQ = 3'h4;
    localparam logic [2:0] FRAME_NONE = 3'h0;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_SHORT_JUMP,
        OP_CMP_BRANCH,
        OP_BRANCH_ON_SET_BIT,
        OP_BRANCH_ON_CLEAR_BIT,
        OP_BRANCH_AND_CLEAR_BIT,
        OP_BLOCK_LOCAL_JUMP,
        OP_REGION_LOCAL_JUMP,
        OP_EXTENDED_JUMP,
        OP_WORD_REG_JUMP,
        OP_ACC_DATA_POINTER_REG_JUMP,
        OP_BLOCK_LOCAL_CALL,
        OP_REGION_LOCAL_CALL,
        OP_WORD_REG_CALL,
        OP_EXTENDED_CALL,
        OP_NEAR_GO_BACK,
        OP_EXTENDED_GO_BACK,
        OP_IRQ_ENTRY,
        OP_INTERRUPT_EXIT
    } btu_op_e;

    typedef enum logic [3:0] {
        COND_EQ,
        COND_NE,
        COND_UGT,
        COND_ULT,
        COND_UGE,
        COND_ULE,
        COND_SGT,
        COND_SLT,
        COND_SGE,
        COND_SLE
    } btu_cond_e;

endpackage

// ==== verification/branch_target_unit_tb_top.sv ====
// Self-checking bench for the branch target unit
`timescale 1ns/1ns
module branch_target_unit_tb_top;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, ov = 0, bt = 0, en = 1;
    logic [7:0]  addr = 0, rel = 0, acc = 0, fl = 0, xf = 0, srd, sd, xo;
    logic [31:0] wd = 0, rdat;
    logic [23:0] npc = 0, tgt = 0, pc;
    logic [15:0] wreg = 0, dp = 0;
    logic        rdy, pl, tk, bc, sw, sr, irl, xl;
    btu_pkg::btu_op_e   opc = btu_pkg::OP_NOP;
    btu_pkg::btu_cond_e cnd = btu_pkg::COND_EQ;
    int          err_count = 0, n_compared = 0;
    always #10 clk = ~clk;
    btu_branch_target dut_u
    (
        .REF_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .OP_VALID_IN(ov),
        .OP_CODE_IN(opc), .COND_IN(cnd), .NEXT_PC_IN(npc), .REL_IN(rel),
        .TARGET_IN(tgt), .WORD_REG_IN(wreg), .ACC_IN(acc), .DATA_POINTER_REG_IN(dp),
        .FLAGS_IN(fl), .EXTRA_FLAGS_IN(xf), .BIT_IN(bt),
        .OP_READY_OUT(rdy), .PC_LOAD_OUT(pl), .PC_OUT(pc), .TAKEN_OUT(tk),
        .BIT_CLEAR_OUT(bc), .STK_WR_OUT(sw), .STK_WDATA_OUT(sd),
        .STK_RD_OUT(sr), .STK_RDATA_IN(srd), .IRQ_RELEASE_OUT(irl),
        .EXTRA_FLAGS_LOAD_OUT(xl), .EXTRA_FLAGS_OUT(xo)
    );
    btu_stack_model stk_u
    (
        .clk_in(clk), .rst_in(rst), .wr_in(sw), .rd_in(sr),
        .wdata_in(sd), .rdata_out(srd)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rg(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        #1;
    endtask
    task automatic run(input btu_pkg::btu_op_e o, input logic [23:0] e,
                       input logic t);
        int n;
        n = 0;
        @(posedge clk);
        opc <= o;
        ov <= 1;
        @(posedge clk);
        ov <= 0;
        #1;
        // Bounded wait: longest frame needs ten cycles
        while (pl !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        // A load that never comes is a failure in its own right
        if (n == 20)
            err_count++;
        chk(pc, e);
        chk(tk, t);
    endtask
    // Expected {taken, pc} for jumps and branches
    function automatic logic [24:0] want(input btu_pkg::btu_op_e o);
        logic [23:0] br;
        logic [9:0]  c;
        logic        z, cy, lt;
        z = xf[btu_pkg::XFLAG_Z_BIT];
        cy = fl[btu_pkg::FLAG_CY_BIT];
        lt = xf[btu_pkg::XFLAG_N_BIT] ^ fl[btu_pkg::FLAG_OV_BIT];
        c = {lt | z, !lt, lt, !lt & !z, cy | z, !cy, cy, !cy & !z, !z, z};
        br = {npc[23:8], npc[7:0] + rel};
        case (o)
            btu_pkg::OP_SHORT_JUMP: return {1'b1, npc + {{16{rel[7]}}, rel}};
            btu_pkg::OP_BLOCK_LOCAL_JUMP: return {1'b1, npc[23:11], tgt[10:0]};
            btu_pkg::OP_REGION_LOCAL_JUMP: return {1'b1, npc[23:16], tgt[15:0]};
            btu_pkg::OP_EXTENDED_JUMP: return {1'b1, tgt};
            btu_pkg::OP_WORD_REG_JUMP: return {1'b1, npc[23:16], wreg};
            btu_pkg::OP_ACC_DATA_POINTER_REG_JUMP: return {1'b1, 8'hFF, dp + {8'h00, acc}};
            btu_pkg::OP_CMP_BRANCH: return {c[cnd], c[cnd] ? br : npc};
            btu_pkg::OP_BRANCH_ON_CLEAR_BIT: return {!bt, bt ? npc : br};
            btu_pkg::OP_BRANCH_ON_SET_BIT,
            btu_pkg::OP_BRANCH_AND_CLEAR_BIT: return {bt, bt ? br : npc};
            default: return {1'b1, npc};
        endcase
    endfunction
    task automatic callret(input btu_pkg::btu_op_e c, input btu_pkg::btu_op_e r,
                           input logic [23:0] et, input logic [23:0] er,
                           input logic [31:0] fr, input int nb);
        run(c, et, 1'b1);
        for (int k = 0; k < nb; k++)
            chk(stk_u.mem[k], fr[8 * (nb - 1 - k) +: 8]);
        run(r, er, 1'b1);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        btu_pkg::btu_op_e o;
        logic [24:0]      w;
        void'($urandom(54));
        repeat (5) @(posedge clk);
        rst <= 0;
        rg(btu_pkg::REG_CONFIG, 0, 0);
        chk(rdat, 0);
        rg(8'hFC, 0, 0);
        chk(rdat, 0);
        $display("Done: reset and registers");
        for (int rep = 0; rep < 20; rep++)
            for (int i = 0; i <= 10; i++)
            begin
                o = btu_pkg::btu_op_e'(i);
                @(posedge clk);
                npc <= 24'($urandom);
                rel <= (rep == 0) ? 8'h80 : (rep == 1) ? 8'h7F : 8'($urandom);
                tgt <= 24'($urandom);
                {wreg, acc, bt} <= 25'($urandom);
                {dp, fl, xf} <= $urandom;
                cnd <= btu_pkg::btu_cond_e'(rep % 10);
                #1 w = want(o);
                run(o, w[23:0], w[24]);
                chk(bc, o == btu_pkg::OP_BRANCH_AND_CLEAR_BIT && bt);
            end
        rg(btu_pkg::REG_TARGET, 0, 0);
        chk(rdat, {8'h00, pc});
        // Enable low: a standing request must not be taken
        @(posedge clk);
        en <= 0;
        ov <= 1;
        opc <= btu_pkg::OP_EXTENDED_JUMP;
        repeat (3) @(posedge clk);
        en <= 1;
        ov <= 0;
        #1 chk({pl, rdy, pc}, {2'b01, w[23:0]});
        rg(btu_pkg::REG_STATUS, 0, 0);
        chk(rdat, {30'h0, w[24], 1'b0});
        $display("Done: jumps and branches");
        callret(btu_pkg::OP_BLOCK_LOCAL_CALL, btu_pkg::OP_NEAR_GO_BACK,
                {npc[23:11], tgt[10:0]}, npc, {npc[7:0], npc[15:8]}, 2);
        callret(btu_pkg::OP_REGION_LOCAL_CALL, btu_pkg::OP_NEAR_GO_BACK,
                {npc[23:16], tgt[15:0]}, npc, {npc[7:0], npc[15:8]}, 2);
        callret(btu_pkg::OP_WORD_REG_CALL, btu_pkg::OP_NEAR_GO_BACK,
                {npc[23:16], wreg}, npc, {npc[7:0], npc[15:8]}, 2);
        callret(btu_pkg::OP_EXTENDED_CALL, btu_pkg::OP_EXTENDED_GO_BACK, tgt,
                npc, {npc[23:16], npc[7:0], npc[15:8]}, 3);
        callret(btu_pkg::OP_IRQ_ENTRY, btu_pkg::OP_INTERRUPT_EXIT, tgt,
                {8'hFF, npc[15:0]}, {npc[7:0], npc[15:8]}, 2);
        chk({irl, xl}, 2'b10);
        rg(btu_pkg::REG_CONFIG, 1, 1);
        rg(btu_pkg::REG_CONFIG, 0, 0);
        chk(rdat, 1);
        callret(btu_pkg::OP_IRQ_ENTRY, btu_pkg::OP_INTERRUPT_EXIT, tgt, npc,
                {xf, npc[23:16], npc[7:0], npc[15:8]}, 4);
        chk({irl, xl, xo}, {2'b11, xf});
        $display("Done: calls, returns and frames");
        end_of_test();
    end
endmodule

// ==== verification/btu_stack_model.sv ====
// Behavioural stack memory standing at the far side of the unit
`timescale 1ns/1ns
module btu_stack_model
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] wdata_in,
    output logic [7:0]      rdata_out
);
    logic [7:0] mem [0:7];
    int         sp;
    // Last-in first-out, so pops return bytes in reverse push order
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            sp <= 0;
        else if (wr_in)
        begin
            mem[sp] <= wdata_in;
            sp <= sp + 1;
        end
        else if (rd_in)
            sp <= sp - 1;
    // Byte stands only in the cycle after the read; otherwise it toggles
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            rdata_out <= 8'h00;
        else
            rdata_out <= (rd_in && !wr_in) ? mem[sp - 1] : ~rdata_out;
endmodule
